/* File: clk_div_enable.v */
// Divider making a one-cycle enable every divide_in cycles.
// Assumes divide_in is at least 2; a smaller new value may cut a count short.
`timescale 1ns/1ps
`include "clk_strap_regs.vh"
module clk_div_enable (
  input wire core_clk_in,
  input wire rst_in,
  input wire [7:0] divide_in,
  output reg tick_out
);
  reg [7:0] count_r;
  reg [7:0] count_nxt;

  always @* begin
    count_nxt = count_r + `DIV_STEP;
    if (count_nxt >= divide_in) begin
      count_nxt = `DIV_COUNT_RST;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      count_r <= `DIV_COUNT_RST;
      tick_out <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_out <= (count_nxt == `DIV_COUNT_RST);
    end
  end
endmodule

/* File: clk_strap_regs.vh */
// Constants for the reset-time clock ratio strap decoder.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
// Functional notes
// - Decode 4-bit platform strap; nine codes reserved
// - Decode 5-bit core strap into six ratios
// - Memory clock is half platform clock
// - Local clock is platform divided by divider
// - Strap pull-ups enabled during reset and for one cycle after it
`ifndef CLK_STRAP_REGS_VH
`define CLK_STRAP_REGS_VH

// ==========================================================
// Avalon register map (word addresses x4)
`define REG_STATUS 4'h0
`define REG_DIVIDER 4'h4
`define REG_STATUS_RST 32'h0000_0000
`define DIVIDER_RST 8'h04
`define DIVIDER_MIN 8'h02
`define DIV_MSB 7
`define DIV_COUNT_RST 8'h00
`define DIV_STEP 8'h01
`define READ_IDLE 32'h0000_0000

// ==========================================================
// Platform ratio strap codes
`define PLAT_2 4'h2
`define PLAT_3 4'h3
`define PLAT_4 4'h4
`define PLAT_5 4'h5
`define PLAT_6 4'h6
`define PLAT_8 4'h8
`define PLAT_9 4'h9
`define RATIO_NONE 4'h0
`define RATIO_W 4

// ==========================================================
// Core ratio strap codes; ratio held in halves
`define CORE_2_0 5'h08
`define CORE_2_5 5'h0C
`define CORE_3_0 5'h10
`define CORE_3_5 5'h1C
`define CORE_4_0 5'h14
`define CORE_4_5 5'h0E
`define HALVES_2_0 4'h4
`define HALVES_2_5 4'h5
`define HALVES_3_0 4'h6
`define HALVES_3_5 4'h7
`define HALVES_4_0 4'h8
`define HALVES_4_5 4'h9

// ==========================================================
// Field positions in the status word
`define ST_PLAT_LSB 0
`define ST_CORE_LSB 8
`define ST_PVALID 16
`define ST_CVALID 17
`define ST_LATCHED 18

`endif

/* File: pll_ratio_strap_decode.v */
// Strap sampling, ratio decode and derived clock enables.
// Assumes core_clk_in stands for the platform clock; board drives the straps.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "clk_strap_regs.vh"
module pll_ratio_strap_decode (
  input wire core_clk_in,
  input wire rst_in,
  input wire [3:0] platform_ratio_strap_in,
  input wire [4:0] core_ratio_strap_in,
  output wire strap_pullup_en_out,
  output reg [3:0] platform_ratio_out,
  output reg [3:0] core_ratio_halves_out,
  output reg platform_valid_out,
  output reg core_valid_out,
  output reg config_invalid_out,
  output wire memory_bus_clk_en_out,
  output wire local_bus_clock_out,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest
);
  // ==========================================================
  // Declarations
  localparam [2:0] ST_ARMED = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_FAULT = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] plat_dec;
  reg [3:0] core_dec;
  reg plat_ok;
  reg core_ok;
  reg mem_phase_r;
  reg [7:0] local_bus_clock_divider_r;
  reg ack_r;
  reg [31:0] status_word;
  reg [31:0] read_word;
  wire sample_now;
  wire latched;
  wire bus_req;
  wire div_write;
  wire div_legal;

  // ==========================================================
  // Platform ratio decode
  always @* begin
    plat_ok = 1'b1;
    case (platform_ratio_strap_in)
      `PLAT_2, `PLAT_3, `PLAT_4, `PLAT_5, `PLAT_6, `PLAT_8, `PLAT_9: begin
        plat_dec = platform_ratio_strap_in;
      end
      default: begin
        // Reserved codes carry no ratio at all
        plat_dec = `RATIO_NONE;
        plat_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Core ratio decode, in halves so 2.5:1 stays an integer
  always @* begin
    core_ok = 1'b1;
    case (core_ratio_strap_in)
      `CORE_2_0: begin
        core_dec = `HALVES_2_0;
      end
      `CORE_2_5: begin
        core_dec = `HALVES_2_5;
      end
      `CORE_3_0: begin
        core_dec = `HALVES_3_0;
      end
      `CORE_3_5: begin
        core_dec = `HALVES_3_5;
      end
      `CORE_4_0: begin
        core_dec = `HALVES_4_0;
      end
      `CORE_4_5: begin
        core_dec = `HALVES_4_5;
      end
      default: begin
        core_dec = `RATIO_NONE;
        core_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Capture sequencer
  // Armed through reset and one cycle past it; straps settle from the pull-ups
  always @* begin
    case (state_r)
      ST_ARMED: begin
        if (plat_ok && core_ok) begin
          state_nxt = ST_HOLD;
        end else begin
          state_nxt = ST_FAULT;
        end
      end
      ST_HOLD: begin
        state_nxt = ST_HOLD;
      end
      ST_FAULT: begin
        state_nxt = ST_FAULT;
      end
      default: begin
        // A corrupt code must never re-arm the capture
        state_nxt = ST_FAULT;
      end
    endcase
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= ST_ARMED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sample_now = (state_r == ST_ARMED);
  assign latched = ~sample_now;
  assign strap_pullup_en_out = rst_in | sample_now;

  // ==========================================================
  // Ratio latch, once per reset
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      platform_ratio_out <= `RATIO_NONE;
      core_ratio_halves_out <= `RATIO_NONE;
      platform_valid_out <= 1'b0;
      core_valid_out <= 1'b0;
      config_invalid_out <= 1'b0;
    end else if (sample_now) begin
      platform_ratio_out <= plat_dec;
      core_ratio_halves_out <= core_dec;
      platform_valid_out <= plat_ok;
      core_valid_out <= core_ok;
      config_invalid_out <= ~(plat_ok & core_ok);
    end
  end

  // ==========================================================
  // Derived clock enables
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      mem_phase_r <= 1'b0;
    end else begin
      mem_phase_r <= ~mem_phase_r;
    end
  end
  assign memory_bus_clk_en_out = mem_phase_r;

  clk_div_enable u_local_div (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .divide_in(local_bus_clock_divider_r),
    .tick_out(local_bus_clock_out)
  );

  // ==========================================================
  // Avalon slave, one wait cycle per access
  // Writes land at the edge that completes the transfer, not the first one
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign div_write = avs_write & ack_r & (avs_address == `REG_DIVIDER);
  // Below two would leave the local clock stuck
  assign div_legal = (avs_writedata[`DIV_MSB:0] >= `DIVIDER_MIN);

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= avs_waitrequest;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      local_bus_clock_divider_r <= `DIVIDER_RST;
    end else if (div_write && div_legal) begin
      local_bus_clock_divider_r <= avs_writedata[`DIV_MSB:0];
    end
  end

  // ==========================================================
  // Read words
  always @* begin
    status_word = `READ_IDLE;
    status_word[`ST_PLAT_LSB +: `RATIO_W] = platform_ratio_out;
    status_word[`ST_CORE_LSB +: `RATIO_W] = core_ratio_halves_out;
    status_word[`ST_PVALID] = platform_valid_out;
    status_word[`ST_CVALID] = core_valid_out;
    status_word[`ST_LATCHED] = latched;
    read_word = `READ_IDLE;
    case (avs_address)
      `REG_STATUS: begin
        read_word = status_word;
      end
      `REG_DIVIDER: begin
        read_word[`DIV_MSB:0] = local_bus_clock_divider_r;
      end
      default: begin
        // Unmapped addresses read as zero
        read_word = `READ_IDLE;
      end
    endcase
  end

  // Loaded on the waiting edge, so it stands when waitrequest drops
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_readdata <= `REG_STATUS_RST;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= read_word;
    end
  end
endmodule

/* File: pll_ratio_strap_decode_chk.sv */
// Port checker for the strap decoder.
// Assumes straps are latched at the first edge after reset.
`timescale 1ns/1ps
module pll_ratio_strap_decode_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire [3:0] platform_ratio_strap_in,
  input wire [4:0] core_ratio_strap_in,
  input wire strap_pullup_en_out,
  input wire [3:0] platform_ratio_out,
  input wire [3:0] core_ratio_halves_out,
  input wire config_invalid_out,
  input wire memory_bus_clk_en_out,
  input wire local_bus_clock_out,
  input wire avs_read,
  input wire avs_waitrequest
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic arm_r;
  logic [3:0] p_r;
  logic [4:0] c_r;
  // Own copy of the latch, so later strap changes do not move the reference
  always_ff @(posedge core_clk_in) begin
    arm_r <= rst_in;
    if (arm_r && !rst_in) begin
      p_r <= platform_ratio_strap_in;
      c_r <= core_ratio_strap_in;
    end
  end
  wire [3:0] pe = (p_r inside {2, 3, 4, 5, 6, 8, 9}) ? p_r : 4'h0;
  wire [3:0] ch = c_r == 5'h08 ? 4'h4 : c_r == 5'h0C ? 4'h5 : c_r == 5'h10 ? 4'h6 :
    c_r == 5'h1C ? 4'h7 : c_r == 5'h14 ? 4'h8 : c_r == 5'h0E ? 4'h9 : 4'h0;
  sequence s_taken;
    avs_read && avs_waitrequest;
  endsequence
  AST_PLAT: assert property (!$past(rst_in) |-> platform_ratio_out == pe)
    else $error("platform ratio decode wrong");
  AST_CORE: assert property (!$past(rst_in) |-> core_ratio_halves_out == ch)
    else $error("core ratio decode wrong");
  AST_INV: assert property (!$past(rst_in) |-> config_invalid_out == (pe == 0 || ch == 0))
    else $error("invalid flag wrong");
  AST_HOLD: assert property (!$past(rst_in, 2) && !$past(rst_in) |->
    $stable(platform_ratio_out) && $stable(core_ratio_halves_out)) else $error("ratio moved");
  AST_PULL: assert property (!$past(rst_in) |-> !strap_pullup_en_out)
    else $error("pull-up left on");
  AST_MEM: assert property (!$past(rst_in, 2) && !$past(rst_in) |->
    memory_bus_clk_en_out != $past(memory_bus_clk_en_out)) else $error("memory enable stuck");
  AST_LCL: assert property (local_bus_clock_out |=> !local_bus_clock_out)
    else $error("local tick too long");
  AST_WAIT: assert property (s_taken |=> !avs_waitrequest)
    else $error("read wait not one cycle");
endmodule
bind pll_ratio_strap_decode pll_ratio_strap_decode_chk chk (.*);

/* File: pll_ratio_strap_decode_tb_top.sv */
// Bench: strap sweep, status reads, divider ticks.
// Assumes one clock and the board model on the straps.
`timescale 1ns/1ps
module pll_ratio_strap_decode_tb_top;
  logic clk = 0, rst = 1, rd = 0, wr = 0, tick, pu, mem, pv, cv, inv, wreq, legal;
  logic [3:0] addr = 4'h0, pr, chv, pc = 4'h0, ps;
  logic [4:0] cc = 5'h00, cs;
  logic [31:0] wd = 32'h0, rdata, q;
  int n_mismatch = 0, checked = 0, seed = 82289, cyc = 0, d, t, i, k, pe;
  int pl[$] = '{2, 3, 4, 5, 6, 8, 9};
  int cl[$] = '{8, 12, 16, 28, 20, 14};
  strap_board_model board (.plat_code_in(pc), .core_code_in(cc), .plat_strap_out(ps),
    .core_strap_out(cs), .board_legal_out(legal));
  pll_ratio_strap_decode dut (.core_clk_in(clk), .rst_in(rst), .platform_ratio_strap_in(ps),
    .core_ratio_strap_in(cs), .strap_pullup_en_out(pu), .platform_ratio_out(pr),
    .core_ratio_halves_out(chv), .platform_valid_out(pv), .core_valid_out(cv),
    .config_invalid_out(inv), .memory_bus_clk_en_out(mem), .local_bus_clock_out(tick),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(wreq));
  task ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= v;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task period(output int p);
    p = 0;
    do @(posedge clk); while (tick !== 1'b1);
    do begin
      @(posedge clk);
      p++;
    end while (tick !== 1'b1);
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  // Hang guard; the whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    for (i = 0; i < 40; i++) begin
      pc <= i < 16 ? i[3:0] : 4'($random(seed));
      cc <= i < 16 ? cl[i % 6][4:0] : 5'($random(seed));
      rst <= 1'b1;
      @(posedge clk);
      ck(pu, 1);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      pe = (pc inside {pl}) ? pc : 0;
      k = 0;
      foreach (cl[j]) if (cl[j] == cc) k = j + 4;
      ck(pr, pe);
      ck(chv, k);
      ck({pv, cv, inv}, {pe != 0, k != 0, pe == 0 || k == 0});
      ck(inv & legal, 0);
      ck(mem, 0);
      ck(pu, 0);
      pc <= 4'($random(seed));
      bus(0, 4'h0, 32'h0);
      ck(q, {13'h0, 1'b1, k != 0, pe != 0, 4'h0, k[3:0], 4'h0, pe[3:0]});
      ck(pr, pe);
    end
    bus(0, 4'hC, 32'h0);
    ck(q, 0);
    bus(0, 4'h4, 32'h0);
    ck(q, 4);
    for (i = 0; i < 4; i++) begin
      d = i == 0 ? 2 : 2 + {$random(seed)} % 8;
      bus(1, 4'h4, d);
      bus(1, 4'h4, 32'h1);
      bus(0, 4'h4, 32'h0);
      ck(q, d);
      period(t);
      period(t);
      ck(t, d);
    end
    tally_and_finish;
  end
endmodule

/* File: strap_board_model.sv */
// Board side: resistors setting both ratio straps, plus the oscillator.
// Assumes the bench picks the codes, legal or not; legality is reported.
`timescale 1ns/1ps
module strap_board_model #(
  parameter int REF_KHZ = 100000,
  parameter int CORE_MAX_KHZ = 1500000,
  parameter int FIFO_KHZ = 95000
) (
  input wire logic [3:0] plat_code_in,
  input wire logic [4:0] core_code_in,
  output logic [3:0] plat_strap_out,
  output logic [4:0] core_strap_out,
  output logic board_legal_out
);
  int plat_mul;
  int halves;
  int plat_khz;
  int core_khz;
  int mem_khz;

  // Always driven hard; weak device pull-ups never decide a code
  assign plat_strap_out = plat_code_in;
  assign core_strap_out = core_code_in;

  always_comb begin
    plat_mul = (plat_code_in inside {2, 3, 4, 5, 6, 8, 9}) ? int'(plat_code_in) : 0;
    case (core_code_in)
      5'h08: halves = 4;
      5'h0C: halves = 5;
      5'h10: halves = 6;
      5'h1C: halves = 7;
      5'h14: halves = 8;
      5'h0E: halves = 9;
      default: halves = 0;
    endcase
    plat_khz = REF_KHZ * plat_mul;
    core_khz = plat_khz * halves / 2;
    mem_khz = plat_khz / 2;
    // One FIFO clock serves both modes; the GMII bound is the tighter one
    board_legal_out = REF_KHZ >= 66000 && REF_KHZ <= 167000
      && (plat_khz == 400000 || (plat_khz >= 500000 && plat_khz <= 600000))
      && mem_khz >= 200000 && mem_khz <= 300000
      && core_khz >= 800000 && core_khz <= CORE_MAX_KHZ
      && FIFO_KHZ * 42 <= plat_khz * 10
      && FIFO_KHZ * 32 <= plat_khz * 10;
  end
endmodule
